/* File: design/tcpg_pkg.sv */
package tcpg_pkg;

  // =====================================================================
  // register map, byte addresses on the apb bus
  // =====================================================================
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_CA_LO = 12'h00c;
  localparam logic [11:0] ADDR_CA_HI = 12'h010;
  localparam logic [11:0] ADDR_CB_LO = 12'h014;
  localparam logic [11:0] ADDR_CB_HI = 12'h018;
  localparam logic [11:0] ADDR_COUNT = 12'h01c;

  // =====================================================================
  // field codes and values
  // =====================================================================
  localparam logic [2:0] MODE_PPG = 3'b011;
  localparam logic [2:0] MODE_PWM = 3'b110;
  localparam logic [1:0] NC_OFF = 2'b00;
  localparam logic [1:0] NC_S2 = 2'b01;
  localparam logic [1:0] NC_S4 = 2'b10;
  localparam logic [1:0] NC_S256 = 2'b11;
  localparam logic [3:0] NC_LOG_S2 = 4'h1;
  localparam logic [3:0] NC_LOG_S4 = 4'h2;
  localparam logic [3:0] NC_LOG_S256 = 4'h8;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam int STAT_CPA = 0;
  localparam int STAT_CPB = 1;
  localparam int STAT_OVF = 2;
  localparam logic [2:0] STAT_RST = 3'h0;

  typedef struct packed {
    logic start_edge;        // 0 rising, 1 falling
    logic capture_style;     // 0 double edge, 1 single edge
    logic [1:0] source_clock_select;
    logic [2:0] operating_mode_field;
  } tcpg_mode_t;

  typedef struct packed {
    logic [1:0] noise_filter_setting;
    logic double_buffer_enable;
    logic output_initial_level;
    logic one_shot_select;
    logic overflow_irq_enable;
    logic run_bit;
  } tcpg_ctrl_t;

  localparam tcpg_mode_t MODE_RST = 7'h00;
  localparam tcpg_ctrl_t CTRL_RST = 7'h00;

  typedef enum logic [1:0] {
    ST_WAIT_START = 2'b00,
    ST_MEASURE = 2'b01,
    ST_AFTER_B = 2'b10
  } tcpg_pw_state_t;

endpackage : tcpg_pkg

/* File: design/tcpg_timer.sv */
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) double edge: next start edge captures count into a, flags, irq, zeroes
// (R2) single edge: opposite edge stops and zeroes; start edge irqs, resumes
// (R3) overflow while measuring sets flag; irq only when overflow enable set
// (R4) reading status clears both capture flags and the overflow flag
// (R5) software reads captures before next start edge, as 16-bit words
// (R6) clearing run bit stops counter and zeroes it
// (R7) opposite edge first after start: no capture, no irq, wait start
// (R8) mode 011 selects pulse output; one-shot bit picks one-shot/continuous
// (R9) software keeps a above b and sets the pin as output first
// (R10) initial level bit sets idle and first level of pulse output
// (R11) while running, mode, overflow enable and initial level are locked
// (R12) count equal to b drives output opposite to initial level
// (R13) count equal to a restores level, irqs; one-shot clears run bit
// (R14) continuous zeroes counter at a; stop returns pin to initial level
// (R15) one-shot bit writable while running, sampled at end of pulse
// (R16) double buffer: running writes apply at a match; else at once
// (R17) low byte write goes to temp buffer; high byte commits both
// (R18) with double buffer on, reads return last written buffered value
// (R19) writes while stopped update effective value and the buffer
// (R20) noise filter passes a level after three equal samples
// (R21) filter runs when setting nonzero; setting locked while running
// (R22) low-freq mode: 11 samples at fs/2, 00 bypass, 01/10 block pin
// (R23) 16-bit counter increments once per selected source clock tick
module tcpg_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  input wire logic fs_tick,
  input wire logic low_freq_mode,
  output logic pulse_output_pin,
  output logic timer_interrupt_request
);

  // =====================================================================
  // helpers
  // =====================================================================
  function automatic logic pre_hit(input logic [7:0] pre,
                                   input logic [3:0] lg);
    logic [8:0] m;
    m = (9'h001 << lg) - 9'h001;
    return &(pre | ~m[7:0]);
  endfunction : pre_hit

  function automatic logic [15:0] pick(input logic dbf,
                                       input logic [15:0] buf_v,
                                       input logic [15:0] eff_v);
    return dbf ? buf_v : eff_v;
  endfunction : pick

  // =====================================================================
  // state
  // =====================================================================
  tcpg_pkg::tcpg_mode_t mode_r;
  tcpg_pkg::tcpg_ctrl_t ctrl_r;
  tcpg_pkg::tcpg_pw_state_t st_r, st_nxt;
  logic [2:0] stat_r;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] a_eff_r, a_buf_r, b_eff_r, b_buf_r;
  logic [7:0] temp_r;
  logic [7:0] pre_r;
  logic [2:0] hist_r;
  logic filt_r, filt_d_r, fs_half_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  logic setup, acc, wr, rd, running, tick;
  logic rise, fall, start_e, opp_e;
  logic is_ppg, is_pwm;
  logic cap_a, cap_b, ovf_ev, pw_irq, match_a, match_b, shot_stop;
  logic run_start;
  logic sample, block_pin;
  logic [3:0] nc_log;
  logic [2:0] nh, stat_clr, stat_set;
  logic [15:0] hi_val;
  logic [31:0] rd_val;
  logic addr_ok;

  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign running = ctrl_r.run_bit;
  assign is_ppg = mode_r.operating_mode_field == tcpg_pkg::MODE_PPG;
  assign is_pwm = mode_r.operating_mode_field == tcpg_pkg::MODE_PWM;
  assign hi_val = {pwdata[7:0], temp_r};
  assign run_start = wr & (paddr == tcpg_pkg::ADDR_CTRL) & pwdata[0]
                     & ~running;

  // =====================================================================
  // prescaler and source clock tick
  // =====================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 8'h00;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end

  // (R23) tick per source clock
  assign tick = pre_hit(pre_r, {2'b00, mode_r.source_clock_select});

  // =====================================================================
  // noise canceller
  // =====================================================================
  always_comb begin
    nc_log = tcpg_pkg::NC_LOG_S2;
    unique case (ctrl_r.noise_filter_setting)
      tcpg_pkg::NC_S4: nc_log = tcpg_pkg::NC_LOG_S4;
      tcpg_pkg::NC_S256: nc_log = tcpg_pkg::NC_LOG_S256;
      tcpg_pkg::NC_OFF, tcpg_pkg::NC_S2: nc_log = tcpg_pkg::NC_LOG_S2;
    endcase
  end

  // (R22) low-freq sampling and pin blocking
  assign block_pin = low_freq_mode
                     & ((ctrl_r.noise_filter_setting == tcpg_pkg::NC_S2)
                     | (ctrl_r.noise_filter_setting == tcpg_pkg::NC_S4));
  assign sample = low_freq_mode
                  ? (fs_tick & fs_half_r)
                  : pre_hit(pre_r, nc_log);
  assign nh = {hist_r[1:0], timer_input_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_half_r <= 1'b0;
    end else if (fs_tick) begin
      fs_half_r <= ~fs_half_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_r <= 3'h0;
      filt_r <= 1'b0;
    end else if (ctrl_r.noise_filter_setting == tcpg_pkg::NC_OFF) begin
      // (R22) setting 00 bypasses the filter
      filt_r <= timer_input_pin;
    end else if (!block_pin && sample) begin
      // (R20) three equal samples pass the level
      hist_r <= nh;
      if (&nh) begin
        filt_r <= 1'b1;
      end else if (~|nh) begin
        filt_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_d_r <= 1'b0;
    end else begin
      filt_d_r <= filt_r;
    end
  end

  assign rise = filt_r & ~filt_d_r;
  assign fall = ~filt_r & filt_d_r;
  assign start_e = mode_r.start_edge ? fall : rise;
  assign opp_e = mode_r.start_edge ? rise : fall;

  // =====================================================================
  // counter and event logic
  // =====================================================================
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cap_a = 1'b0;
    cap_b = 1'b0;
    ovf_ev = 1'b0;
    pw_irq = 1'b0;
    match_a = 1'b0;
    match_b = 1'b0;
    if (!running) begin
      // (R6) stopped counter held at zero
      st_nxt = tcpg_pkg::ST_WAIT_START;
      cnt_nxt = tcpg_pkg::CNT_ZERO;
    end else if (is_pwm) begin
      unique case (st_r)
        tcpg_pkg::ST_WAIT_START: begin
          // (R7) only a start edge begins measuring
          if (start_e) begin
            pw_irq = 1'b1;
            cnt_nxt = tcpg_pkg::CNT_ZERO;
            st_nxt = tcpg_pkg::ST_MEASURE;
          end
        end
        tcpg_pkg::ST_MEASURE: begin
          if (tick) begin
            cnt_nxt = cnt_r + 16'h0001;
            // (R3) overflow while measuring
            ovf_ev = cnt_r == tcpg_pkg::CNT_MAX;
          end
          if (opp_e) begin
            cap_b = 1'b1;
            if (mode_r.capture_style) begin
              // (R2) single edge stops and zeroes
              cnt_nxt = tcpg_pkg::CNT_ZERO;
              st_nxt = tcpg_pkg::ST_WAIT_START;
            end else begin
              // (R1) count keeps its tick on the opposite edge
              st_nxt = tcpg_pkg::ST_AFTER_B;
            end
          end
        end
        tcpg_pkg::ST_AFTER_B: begin
          if (start_e) begin
            // (R1) capture into a and restart
            cap_a = 1'b1;
            cnt_nxt = tcpg_pkg::CNT_ZERO;
            st_nxt = tcpg_pkg::ST_MEASURE;
          end else if (tick) begin
            // (R1) keep counting after opposite edge
            cnt_nxt = cnt_r + 16'h0001;
            ovf_ev = cnt_r == tcpg_pkg::CNT_MAX;
          end
        end
        default: begin
          st_nxt = tcpg_pkg::ST_WAIT_START;
        end
      endcase
    end else if (is_ppg && tick) begin
      // (R12) toggle point
      match_b = cnt_r == b_eff_r;
      if (cnt_r == a_eff_r) begin
        // (R14) period end zeroes counter
        match_a = 1'b1;
        cnt_nxt = tcpg_pkg::CNT_ZERO;
      end else begin
        // (R16) value below count wraps through overflow
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  // (R13) one-shot stop at period end
  // (R15) one-shot bit sampled when the pulse completes
  assign shot_stop = match_a & ctrl_r.one_shot_select;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= tcpg_pkg::ST_WAIT_START;
      cnt_r <= tcpg_pkg::CNT_ZERO;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // =====================================================================
  // interrupt request and pulse output
  // =====================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_interrupt_request <= 1'b0;
    end else begin
      // (R3) overflow irq gated by enable
      // (R13) period match irq
      timer_interrupt_request <= pw_irq | cap_a | cap_b | match_a
                                 | (ovf_ev & ctrl_r.overflow_irq_enable);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_output_pin <= 1'b0;
    end else if (!running || !is_ppg || match_a) begin
      // (R10) idle level from initial level bit
      // (R14) stop returns pin to initial level
      pulse_output_pin <= ctrl_r.output_initial_level;
    end else if (match_b) begin
      // (R12) drive opposite level
      pulse_output_pin <= ~ctrl_r.output_initial_level;
    end
  end

  // =====================================================================
  // mode and control registers
  // =====================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= tcpg_pkg::MODE_RST;
    end else if (wr && paddr == tcpg_pkg::ADDR_MODE && !running) begin
      // (R11) mode locked while running
      // (R8) mode field selects pulse output
      mode_r <= pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= tcpg_pkg::CTRL_RST;
    end else begin
      if (wr && paddr == tcpg_pkg::ADDR_CTRL) begin
        ctrl_r.run_bit <= pwdata[0];
        // (R15) one-shot bit writable any time
        ctrl_r.one_shot_select <= pwdata[2];
        ctrl_r.double_buffer_enable <= pwdata[4];
        if (!running) begin
          // (R11) locked fields
          ctrl_r.overflow_irq_enable <= pwdata[1];
          ctrl_r.output_initial_level <= pwdata[3];
          // (R21) filter setting locked while running
          ctrl_r.noise_filter_setting <= pwdata[6:5];
        end
      end
      if (shot_stop) begin
        // (R13) automatic stop clears run bit
        ctrl_r.run_bit <= 1'b0;
      end
    end
  end

  // =====================================================================
  // status flags
  // =====================================================================
  assign stat_set = {ovf_ev, cap_b, cap_a};
  assign stat_clr = (rd && paddr == tcpg_pkg::ADDR_STAT)
                    ? prdata_r[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= tcpg_pkg::STAT_RST;
    end else begin
      // (R4) read clears flags, a new event wins
      stat_r <= (stat_r & ~stat_clr) | stat_set;
    end
  end

  // =====================================================================
  // compare registers, temp buffer and double buffer
  // =====================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_r <= 8'h00;
    end else if (wr && (paddr == tcpg_pkg::ADDR_CA_LO
                        || paddr == tcpg_pkg::ADDR_CB_LO)) begin
      // (R17) low byte parks in temp buffer
      temp_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_eff_r <= tcpg_pkg::CNT_ZERO;
      a_buf_r <= tcpg_pkg::CNT_ZERO;
    end else if (run_start && is_pwm) begin
      a_eff_r <= tcpg_pkg::CNT_ZERO;
      a_buf_r <= tcpg_pkg::CNT_ZERO;
    end else if (cap_a) begin
      // (R1) count captured into a
      a_eff_r <= cnt_r;
      a_buf_r <= cnt_r;
    end else if (wr && paddr == tcpg_pkg::ADDR_CA_HI) begin
      // (R17) high byte commits both bytes
      a_buf_r <= hi_val;
      // (R16) (R19) immediate unless buffered while running
      if (!(running && ctrl_r.double_buffer_enable)) begin
        a_eff_r <= hi_val;
      end
    end else if (match_a && ctrl_r.double_buffer_enable) begin
      // (R16) buffered value takes effect at a match
      a_eff_r <= a_buf_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_eff_r <= tcpg_pkg::CNT_ZERO;
      b_buf_r <= tcpg_pkg::CNT_ZERO;
    end else if (run_start && is_pwm) begin
      b_eff_r <= tcpg_pkg::CNT_ZERO;
      b_buf_r <= tcpg_pkg::CNT_ZERO;
    end else if (cap_b) begin
      b_eff_r <= cnt_r;
      b_buf_r <= cnt_r;
    end else if (wr && paddr == tcpg_pkg::ADDR_CB_HI) begin
      b_buf_r <= hi_val;
      // (R19) stopped writes reach effective value
      if (!(running && ctrl_r.double_buffer_enable)) begin
        b_eff_r <= hi_val;
      end
    end else if (match_a && ctrl_r.double_buffer_enable) begin
      b_eff_r <= b_buf_r;
    end
  end

  // =====================================================================
  // apb read path, answered with no wait state
  // =====================================================================
  always_comb begin
    rd_val = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (paddr)
      tcpg_pkg::ADDR_MODE: rd_val = {25'h0, mode_r};
      tcpg_pkg::ADDR_CTRL: rd_val = {25'h0, ctrl_r};
      tcpg_pkg::ADDR_STAT: rd_val = {29'h0, stat_r};
      // (R18) buffered value read back when enabled
      tcpg_pkg::ADDR_CA_LO:
        rd_val = {16'h0, pick(ctrl_r.double_buffer_enable, a_buf_r,
                              a_eff_r)};
      tcpg_pkg::ADDR_CA_HI:
        rd_val = {16'h0, pick(ctrl_r.double_buffer_enable, a_buf_r,
                              a_eff_r) >> 8};
      tcpg_pkg::ADDR_CB_LO:
        rd_val = {16'h0, pick(ctrl_r.double_buffer_enable, b_buf_r,
                              b_eff_r)};
      tcpg_pkg::ADDR_CB_HI:
        rd_val = {16'h0, pick(ctrl_r.double_buffer_enable, b_buf_r,
                              b_eff_r) >> 8};
      tcpg_pkg::ADDR_COUNT: rd_val = {16'h0, cnt_r};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr_r <= ~addr_ok;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r & acc;
  assign pready = 1'b1;

endmodule : tcpg_timer

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tin, pout, irq, err;
  logic [31:0] rdat;
  logic fs_tick = 1'b0;
  logic lfm = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int irq_cnt = 0;
  int n, base;
  always #5 pclk = ~pclk;
  tcpg_timer i_tcpg_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_pin(tin),
    .fs_tick(fs_tick), .low_freq_mode(lfm), .pulse_output_pin(pout),
    .timer_interrupt_request(irq));
  tcpg_far_end i_tcpg_far_end (.pclk(pclk), .pulse_output_pin(pout),
    .timer_input_pin(tin));
  // ==================================================================
  // common tasks
  // ==================================================================
  task end_sim;
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd_chk
  task wait_irq(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (irq !== 1'b1);
  endtask : wait_irq
  always @(posedge pclk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    cyc <= cyc + 1;
    fs_tick <= (cyc % 4 == 3);
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // ==================================================================
  // scenarios
  // ==================================================================
  task s_regs;
    rd_chk(tcpg_pkg::ADDR_COUNT, 32'h0);
    rd_chk(tcpg_pkg::ADDR_STAT, 32'h0);
    rd_chk(12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(tcpg_pkg::ADDR_CA_LO, 32'h55);
    rd_chk(tcpg_pkg::ADDR_CA_LO, 32'h0);
    wr(tcpg_pkg::ADDR_CA_HI, 32'h12);
    rd_chk(tcpg_pkg::ADDR_CA_LO, 32'h1255);
  endtask : s_regs
  task s_ppg;
    wr(tcpg_pkg::ADDR_CA_LO, 32'h10);
    wr(tcpg_pkg::ADDR_CA_HI, 32'h00);
    wr(tcpg_pkg::ADDR_CB_LO, 32'h08);
    wr(tcpg_pkg::ADDR_CB_HI, 32'h00);
    wr(tcpg_pkg::ADDR_MODE, 32'h03);
    wr(tcpg_pkg::ADDR_CTRL, 32'h11);
    wait_irq(n);
    wait_irq(n);
    chk(n, 32'd17);
    chk(i_tcpg_far_end.high_w, 32'd8);
    wr(tcpg_pkg::ADDR_CA_LO, 32'h20);
    wr(tcpg_pkg::ADDR_CA_HI, 32'h00);
    rd_chk(tcpg_pkg::ADDR_CA_LO, 32'h20);
    wait_irq(n);
    wait_irq(n);
    chk(n, 32'd33);
    wr(tcpg_pkg::ADDR_MODE, 32'h06);
    wr(tcpg_pkg::ADDR_CTRL, 32'h39);
    rd_chk(tcpg_pkg::ADDR_MODE, 32'h03);
    rd_chk(tcpg_pkg::ADDR_CTRL, 32'h11);
    wr(tcpg_pkg::ADDR_CTRL, 32'h15);
    wait_irq(n);
    repeat (2) @(posedge pclk);
    chk(pout, 32'h0);
    rd_chk(tcpg_pkg::ADDR_CTRL, 32'h14);
    wr(tcpg_pkg::ADDR_CTRL, 32'h08);
    @(posedge pclk);
    chk(pout, 32'h1);
    wr(tcpg_pkg::ADDR_CTRL, 32'h00);
  endtask : s_ppg
  task s_pw;
    wr(tcpg_pkg::ADDR_MODE, 32'h06);
    wr(tcpg_pkg::ADDR_CTRL, 32'h01);
    base = irq_cnt;
    i_tcpg_far_end.drive(1'b0, 10);
    chk(irq_cnt - base, 32'h0);
    i_tcpg_far_end.drive(1'b1, 20);
    chk(irq_cnt - base, 32'h1);
    i_tcpg_far_end.drive(1'b0, 20);
    i_tcpg_far_end.drive(1'b1, 10);
    rd_chk(tcpg_pkg::ADDR_STAT, 32'h3);
    rd_chk(tcpg_pkg::ADDR_STAT, 32'h0);
    apb(1'b0, tcpg_pkg::ADDR_CA_LO, 32'h0);
    chk(32'(rdat >= 32'd39 && rdat <= 32'd41), 32'h1);
    rd_chk(tcpg_pkg::ADDR_CB_LO, 32'd19);
    wr(tcpg_pkg::ADDR_CTRL, 32'h00);
    rd_chk(tcpg_pkg::ADDR_COUNT, 32'h0);
    wr(tcpg_pkg::ADDR_MODE, 32'h26);
    wr(tcpg_pkg::ADDR_CTRL, 32'h01);
    i_tcpg_far_end.drive(1'b0, 10);
    i_tcpg_far_end.drive(1'b1, 10);
    i_tcpg_far_end.drive(1'b0, 10);
    rd_chk(tcpg_pkg::ADDR_COUNT, 32'h0);
    wr(tcpg_pkg::ADDR_CTRL, 32'h00);
  endtask : s_pw
  task s_lowf;
    lfm <= 1'b1;
    wr(tcpg_pkg::ADDR_MODE, 32'h06);
    wr(tcpg_pkg::ADDR_CTRL, 32'h21);
    base = irq_cnt;
    i_tcpg_far_end.drive(1'b1, 40);
    chk(irq_cnt - base, 32'h0);
    wr(tcpg_pkg::ADDR_CTRL, 32'h00);
    wr(tcpg_pkg::ADDR_CTRL, 32'h60);
    repeat (40) @(posedge pclk);
    wr(tcpg_pkg::ADDR_CTRL, 32'h61);
    base = irq_cnt;
    i_tcpg_far_end.drive(1'b0, 40);
    i_tcpg_far_end.drive(1'b1, 40);
    chk(irq_cnt - base, 32'h1);
    wr(tcpg_pkg::ADDR_CTRL, 32'h00);
    lfm <= 1'b0;
  endtask : s_lowf
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_ppg();
    s_pw();
    s_lowf();
    end_sim();
  end
endmodule : tb_top
bind tcpg_timer tcpg_timer_assertions i_tcpg_timer_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_input_pin(timer_input_pin),
  .fs_tick(fs_tick), .low_freq_mode(low_freq_mode),
  .pulse_output_pin(pulse_output_pin),
  .timer_interrupt_request(timer_interrupt_request));

/* File: sim/tcpg_far_end.sv */
`timescale 1ns/1ps
module tcpg_far_end (
  input wire logic pclk,
  input wire logic pulse_output_pin,
  output logic timer_input_pin
);
  int run_w = 0;
  int high_w = 0;
  initial timer_input_pin = 1'b1;
  // ==================================================================
  // input pulse source
  // ==================================================================
  task drive(input logic lvl, input int n);
    timer_input_pin <= lvl;
    repeat (n) @(posedge pclk);
  endtask : drive
  // ==================================================================
  // output pulse width monitor
  // ==================================================================
  always @(posedge pclk) begin
    if (pulse_output_pin === 1'b1) begin
      run_w <= run_w + 1;
    end else begin
      if (run_w != 0) high_w <= run_w;
      run_w <= 0;
    end
  end
endmodule : tcpg_far_end

/* File: sim/tcpg_timer_assertions.sv */
`timescale 1ns/1ps
module tcpg_timer_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_input_pin,
  input wire logic fs_tick,
  input wire logic low_freq_mode,
  input wire logic pulse_output_pin,
  input wire logic timer_interrupt_request
);
  // ==================================================================
  // helper state
  // ==================================================================
  logic acc;
  logic ctrl_seen_r;
  assign acc = psel && penable;
  // set once software has touched the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_seen_r <= 1'b0;
    end else if (acc && pwrite && paddr == tcpg_pkg::ADDR_CTRL) begin
      ctrl_seen_r <= 1'b1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==================================================================
  // assertions
  // ==================================================================
  a_zero_wait_ready: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (acc && paddr > 12'h01c |-> pslverr)
    else $error("no error on unmapped address");
  a_mapped_no_err: assert property (
    acc && paddr <= 12'h01c && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped address");
  a_write_rdata_zero: assert property (acc && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  a_idle_pin_low: assert property (!ctrl_seen_r |-> !pulse_output_pin)
    else $error("pulse output moved before setup");
  a_idle_no_irq: assert property (!ctrl_seen_r |-> !timer_interrupt_request)
    else $error("interrupt before timer start");
  a_count_idle_zero: assert property (acc && !pwrite &&
    paddr == tcpg_pkg::ADDR_COUNT && !ctrl_seen_r |-> prdata == 32'h0)
    else $error("counter moved before start");
  a_status_idle_zero: assert property (acc && !pwrite &&
    paddr == tcpg_pkg::ADDR_STAT && !ctrl_seen_r |-> prdata == 32'h0)
    else $error("status flag set before start");
  a_irq_one_cycle: assert property (
    timer_interrupt_request |=> !timer_interrupt_request)
    else $error("interrupt longer than one cycle");
  c_irq: cover property (timer_interrupt_request);
  c_pin_high: cover property (pulse_output_pin);
  c_slverr: cover property (acc && pslverr);
endmodule : tcpg_timer_assertions
